// file: logic/lrdo_top.sv
// Limit result digital outputs: bound compare, latency, line drive, APB
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - Outputs 1..4 follow first low, first high, second low, second high bounds.
// - Output 5 is the OR of the four bound violations.
// - A reaching reading asserts its line; an inside reading releases it.
// - Asserted level is high for active-high polarity, low for active-low.
// - Pulse mode gives one pulse per failing reading at set polarity.
// - Pulse width defaults to 2 ms, remotely set 0.001 to 99999.999 s.
// - An in-limit reading during a pulse ends it at once.
// - Pulse timing runs independently and does not slow readings.
// - Without hold, master releases when a reading is inside all bounds.
// - With hold, master stays asserted until the control-source stage passes.
// - During scanning a held master releases only when a new scan starts.
// - Output updates about 10 ms after trigger with channel, 2 ms without.
// - Temperature readings may take up to ten times longer to update.
// - External trigger accepted only while its enable pin is high or open.
// - The port trigger input is the same as the trigger-link input.
// - Bounds compare as unitless numbers for every function.
// - Simple scan shares one bound set; advanced scan keeps one per channel.
// - Beeper mode cannot be changed over the remote interface.
// - Open-collector output: transistor off for high, on to pull low.
// - Outputs drive only while the output enable setting is on.
module lrdo_top
   import lrdo_pkg::*;
#(
   parameter int VAL_W = 33,
   parameter int NCH = 8,
   parameter int CH_W = 3,
   parameter int CNT_W = 48,
   parameter int DLY_CHAN_CYC = LRDO_DLY_CHAN_US * LRDO_CLK_MHZ,
   parameter int DLY_NOCH_CYC = LRDO_DLY_NOCH_US * LRDO_CLK_MHZ
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reading and trigger-model events
   input wire logic reading_valid,
   input wire logic signed [VAL_W-1:0] reading_value,
   input wire logic [CH_W-1:0] reading_channel,
   input wire logic control_source_pass,
   input wire logic scan_active,
   input wire logic scan_start,
   // Limit bound set writes, from the limit arithmetic side
   input wire logic bound_we,
   input wire logic [CH_W-1:0] bound_channel,
   input wire logic [1:0] bound_index,
   input wire logic signed [VAL_W-1:0] bound_value,
   input wire logic advanced_scan,
   // Local panel beeper mode
   input wire logic panel_limit_beeper_mode_we,
   input wire lrdo_pkg::lrdo_limit_beeper_mode_e panel_limit_beeper_mode_mode,
   output lrdo_pkg::lrdo_limit_beeper_mode_e limit_beeper_mode,
   // Trigger pins
   input wire logic trigger_in,
   input wire logic trigger_in_enable,
   output logic external_trigger,
   // Open-collector limit outputs
   output logic [LRDO_NOUT-1:0] limit_out,
   output logic [LRDO_NOUT-1:0] limit_oe
);
   logic [31:0] ctrl;
   logic [31:0] pulse_ms;
   logic [31:0] trig_cfg;
   logic signed [VAL_W-1:0] bounds [NCH][LRDO_NLIM];
   logic [LRDO_NLIM-1:0] fail_cap;
   logic [LRDO_NLIM-1:0] fail_now;
   logic [31:0] dly_cnt;
   logic dly_busy;
   logic upd;
   logic [LRDO_NOUT-1:0] line_asserted;
   logic master_held;
   logic [CNT_W-1:0] pulse_cycles;
   logic [CH_W-1:0] sel_ch;
   logic [31:0] dly_load;
   logic acc_wr;
   logic acc_rd;

   // Byte-lane write merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Valid register address decode
   function automatic logic mapped(input logic [7:0] a);
      return a == LRDO_CTRL_OFS || a == LRDO_PULSE_OFS || a == LRDO_STAT_OFS ||
             a == LRDO_TRIG_OFS;
   endfunction : mapped

   assign acc_wr = psel && penable && pwrite && pready;
   assign acc_rd = psel && !penable && !pwrite;

   // APB ready: one wait state, answer in the second access cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   // Error answer for unmapped addresses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && penable && !pready && !mapped(paddr);
      end
   end

   // Control register; beeper field is not written here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= LRDO_CTRL_RST;
      end else if (acc_wr && paddr == LRDO_CTRL_OFS) begin
         ctrl <= merge(ctrl, pwdata, pstrb) & 32'h0000_000f;
      end
   end

   // Pulse width in milliseconds, clamped to the legal span
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pulse_ms <= LRDO_PULSE_MS_RST;
      end else if (acc_wr && paddr == LRDO_PULSE_OFS) begin
         if (merge(pulse_ms, pwdata, pstrb) == 32'h0000_0000) begin
            pulse_ms <= 32'h0000_0001;
         end else if (merge(pulse_ms, pwdata, pstrb) > LRDO_PULSE_MS_MAX) begin
            pulse_ms <= LRDO_PULSE_MS_MAX;
         end else begin
            pulse_ms <= merge(pulse_ms, pwdata, pstrb);
         end
      end
   end

   // Trigger latency selection register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_cfg <= 32'h0000_0000;
      end else if (acc_wr && paddr == LRDO_TRIG_OFS) begin
         trig_cfg <= merge(trig_cfg, pwdata, pstrb) & 32'h0000_0003;
      end
   end

   // Read data, captured in the setup cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (acc_rd) begin
         case (paddr)
            LRDO_CTRL_OFS: prdata <= ctrl | (32'(limit_beeper_mode) << LRDO_LIMIT_BEEPER_MODE_LSB);
            LRDO_PULSE_OFS: prdata <= pulse_ms;
            LRDO_STAT_OFS: prdata <= {25'h0, dly_busy, master_held, line_asserted};
            LRDO_TRIG_OFS: prdata <= trig_cfg;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Beeper mode from the panel only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         limit_beeper_mode <= lrdo_limit_beeper_mode_disabled;
      end else if (panel_limit_beeper_mode_we) begin
         limit_beeper_mode <= panel_limit_beeper_mode_mode;
      end
   end

   // Bound store: per channel in advanced scan, channel 0 shared in simple
   always_ff @(posedge clk) begin
      if (bound_we) begin
         bounds[advanced_scan ? bound_channel : CH_W'(0)][bound_index] <= bound_value;
      end
   end

   assign sel_ch = advanced_scan ? reading_channel : CH_W'(0);

   // Unitless signed compare, order low1, high1, low2, high2
   always_comb begin
      fail_now[0] = reading_value <= bounds[sel_ch][0];
      fail_now[1] = reading_value >= bounds[sel_ch][1];
      fail_now[2] = reading_value <= bounds[sel_ch][2];
      fail_now[3] = reading_value >= bounds[sel_ch][3];
   end

   // Capture results once per reading strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fail_cap <= '0;
      end else if (reading_valid) begin
         fail_cap <= fail_now;
      end
   end

   // Latency load from channel closure and temperature options
   always_comb begin
      dly_load = trig_cfg[LRDO_CHAN_BIT] ? 32'(DLY_CHAN_CYC) : 32'(DLY_NOCH_CYC);
      if (trig_cfg[LRDO_TEMP_BIT]) begin
         dly_load = 32'(dly_load * LRDO_TEMP_MULT);
      end
   end

   // Output latency timer after each reading; a new reading restarts it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dly_cnt <= 32'h0000_0000;
         dly_busy <= 1'b0;
      end else if (reading_valid) begin
         dly_cnt <= dly_load;
         dly_busy <= 1'b1;
      end else if (dly_busy && dly_cnt <= 32'h0000_0001) begin
         dly_busy <= 1'b0;
         dly_cnt <= 32'h0000_0000;
      end else if (dly_busy) begin
         dly_cnt <= dly_cnt - 32'h0000_0001;
      end
   end

   assign upd = dly_busy && dly_cnt <= 32'h0000_0001 && !reading_valid;
   assign pulse_cycles = CNT_W'(pulse_ms) * CNT_W'(LRDO_MS_CYC);

   // Master hold flag, released at control-source pass or new scan
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         master_held <= 1'b0;
      end else if (!ctrl[LRDO_EN_BIT] || !ctrl[LRDO_HOLD_BIT]) begin
         master_held <= 1'b0;
      end else if (upd && |fail_cap) begin
         master_held <= 1'b1;
      end else if (scan_active ? scan_start : control_source_pass) begin
         master_held <= 1'b0;
      end
   end

   // Four bound lines and the master line
   for (genvar g = 0; g < LRDO_NOUT; g++) begin : g_line
      lrdo_line #(.CNT_W(CNT_W)) u_line (
         .clk(clk),
         .rst(rst),
         .enable(ctrl[LRDO_EN_BIT]),
         .pulse_mode(ctrl[LRDO_PULSE_BIT]),
         .active_low(ctrl[LRDO_POL_BIT]),
         .pulse_cycles(pulse_cycles),
         .upd(upd),
         .fail(g == LRDO_MASTER ? (|fail_cap || master_held) : fail_cap[g]),
         .pin_out(limit_out[g]),
         .pin_oe(limit_oe[g]),
         .asserted(line_asserted[g])
      );
   end

   // Trigger-link input gated by its enable pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         external_trigger <= 1'b0;
      end else begin
         external_trigger <= trigger_in && trigger_in_enable;
      end
   end
endmodule : lrdo_top

// file: logic/lrdo_pkg.sv
// Package of constants for the limit result digital output block
package lrdo_pkg;
   // APB register byte offsets
   localparam logic [7:0] LRDO_CTRL_OFS = 8'h00;
   localparam logic [7:0] LRDO_PULSE_OFS = 8'h04;
   localparam logic [7:0] LRDO_STAT_OFS = 8'h08;
   localparam logic [7:0] LRDO_TRIG_OFS = 8'h0c;
   // Control register fields
   localparam int LRDO_EN_BIT = 0;
   localparam int LRDO_PULSE_BIT = 1;
   localparam int LRDO_POL_BIT = 2;
   localparam int LRDO_HOLD_BIT = 3;
   localparam int LRDO_LIMIT_BEEPER_MODE_LSB = 4;
   localparam int LRDO_LIMIT_BEEPER_MODE_W = 2;
   // Trigger register fields
   localparam int LRDO_CHAN_BIT = 0;
   localparam int LRDO_TEMP_BIT = 1;
   // Reset values
   localparam logic [31:0] LRDO_CTRL_RST = 32'h0000_0000;
   // Number of limit lines and bound indices
   localparam int LRDO_NLIM = 4;
   localparam int LRDO_NOUT = 5;
   localparam int LRDO_MASTER = 4;
   // Timing, in microseconds, and the clock rate in MHz
   localparam int LRDO_CLK_MHZ = 250;
   localparam int LRDO_PULSE_US = 2000;
   localparam int LRDO_DLY_CHAN_US = 10000;
   localparam int LRDO_DLY_NOCH_US = 2000;
   localparam int LRDO_TEMP_MULT = 10;
   // Pulse width register counts in milliseconds (0.001 s units)
   localparam int LRDO_MS_CYC = LRDO_CLK_MHZ * 1000;
   localparam logic [31:0] LRDO_PULSE_MS_RST = 32'(LRDO_PULSE_US / 1000);
   localparam logic [31:0] LRDO_PULSE_MS_MAX = 32'h05f5_e0ff; // 99999999 ms
   // Beeper modes, changeable only on the panel side
   typedef enum logic [1:0] {lrdo_limit_beeper_mode_disabled, lrdo_limit_beeper_mode_inside, lrdo_limit_beeper_mode_outside}
      lrdo_limit_beeper_mode_e;
endpackage : lrdo_pkg

// file: logic/lrdo_line.sv
// One limit output line with level or pulse drive and open-collector stage
`timescale 1ns/1ps
module lrdo_line #(
   parameter int CNT_W = 48
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic enable,
   input wire logic pulse_mode,
   input wire logic active_low,
   input wire logic [CNT_W-1:0] pulse_cycles,
   // Update from the latency stage
   input wire logic upd,
   input wire logic fail,
   // Open-collector pin
   output logic pin_out,
   output logic pin_oe,
   output logic asserted
);
   logic [CNT_W-1:0] cnt;
   logic next_asserted;

   // Next asserted state: level follows fail, pulse counts down
   always_comb begin
      next_asserted = asserted;
      if (!enable) begin
         next_asserted = 1'b0;
      end else if (upd) begin
         next_asserted = fail;
      end else if (pulse_mode && asserted && cnt <= CNT_W'(1)) begin
         next_asserted = 1'b0;
      end
   end

   // Line state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         asserted <= 1'b0;
      end else begin
         asserted <= next_asserted;
      end
   end

   // Pulse timer runs on its own and does not stall readings
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else if (upd && fail) begin
         cnt <= pulse_cycles;
      end else if (cnt != '0) begin
         cnt <= cnt - CNT_W'(1);
      end
   end

   // Pin drive: transistor on pulls low, off lets pull-up raise the line
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_oe <= 1'b0;
         pin_out <= 1'b0;
      end else begin
         pin_out <= 1'b0;
         pin_oe <= enable && (next_asserted == active_low); // Transistor off while disabled
      end
   end
endmodule : lrdo_line

// file: testbench/lrdo_assertions.sv
// Port timing checker for the limit output block
`timescale 1ns/1ps
module lrdo_checker
   import lrdo_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   // Events and trigger pins
   input wire logic reading_valid,
   input wire logic trigger_in,
   input wire logic trigger_in_enable,
   input wire logic external_trigger,
   input wire logic panel_limit_beeper_mode_we,
   input wire lrdo_pkg::lrdo_limit_beeper_mode_e limit_beeper_mode,
   // Limit outputs
   input wire logic [LRDO_NOUT-1:0] limit_out,
   input wire logic [LRDO_NOUT-1:0] limit_oe
);
   logic en;
   logic pol;
   logic [1:0] quiet;
   logic [4:0] act;
   logic ctl_wr;
   // Asserted lines as seen through the chosen sense
   assign act = limit_oe ^ {5{~pol}};
   assign ctl_wr = psel && penable && pready && pwrite && paddr == LRDO_CTRL_OFS && pstrb[0];
   // Shadow of enable and sense, with a settle count after each control write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en <= 1'b0;
         pol <= 1'b0;
         quiet <= 2'h0;
      end else if (ctl_wr) begin
         en <= pwdata[LRDO_EN_BIT];
         pol <= pwdata[LRDO_POL_BIT];
         quiet <= 2'h0;
      end else if (quiet != 2'h3) begin
         quiet <= quiet + 2'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   property p_answer;
      s_setup ##1 s_access |-> !pready ##1 pready;
   endproperty
   a_answer: assert property (p_answer) else $error("late bus answer");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_oc;
      limit_out == 5'h00;
   endproperty
   a_oc: assert property (p_oc) else $error("line driven high");
   property p_trig;
      external_trigger == $past(trigger_in && trigger_in_enable);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger gate wrong");
   property p_off;
      !en [*2] |-> limit_oe == 5'h00;
   endproperty
   a_off: assert property (p_off) else $error("driven while off");
   property p_or;
      en && quiet == 2'h3 && |act[3:0] |-> act[4];
   endproperty
   a_or: assert property (p_or) else $error("master not set");
   property p_settle;
      reading_valid && quiet == 2'h3 |=> $stable(limit_oe) [*4];
   endproperty
   a_settle: assert property (p_settle) else $error("update too early");
   property p_limit_beeper_mode;
      $changed(limit_beeper_mode) |-> $past(panel_limit_beeper_mode_we);
   endproperty
   a_limit_beeper_mode: assert property (p_limit_beeper_mode) else $error("beeper changed");
endmodule : lrdo_checker

bind lrdo_top lrdo_checker chk_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .pready, .pslverr, .reading_valid, .trigger_in, .trigger_in_enable,
   .external_trigger, .panel_limit_beeper_mode_we, .limit_beeper_mode, .limit_out, .limit_oe);

// file: testbench/lrdo_far_side.sv
// Far-side loads: pulled-up output lines and the trigger enable pin
`timescale 1ns/1ps
module lrdo_far_side
   import lrdo_pkg::*;
(
   // Open-collector outputs
   input wire logic [LRDO_NOUT-1:0] limit_out,
   input wire logic [LRDO_NOUT-1:0] limit_oe,
   // Trigger enable pin, open unless pulled low
   input wire logic hold_trig_low,
   output logic trig_en_pin,
   // Line levels at the loads
   output logic [LRDO_NOUT-1:0] pin_level
);
   // Pull-up wins unless the transistor is on
   always_comb begin
      for (int i = 0; i < LRDO_NOUT; i++) begin
         pin_level[i] = limit_oe[i] ? limit_out[i] : 1'b1;
      end
   end
   // An open pin reads high
   assign trig_en_pin = hold_trig_low ? 1'b0 : 1'b1;
endmodule : lrdo_far_side

// file: testbench/tb.sv
// Self-checking bench for the limit result digital outputs
`timescale 1ns/1ps
module tb;
   import lrdo_pkg::*;
   logic clk, rst, psel, penable, pwrite, reading_valid, control_source_pass, err;
   logic scan_active, scan_start, bound_we, advanced_scan, panel_limit_beeper_mode_we, trigger_in;
   logic hold_trig_low, trig_en_pin, pready, pslverr, external_trigger;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] pstrb;
   logic signed [32:0] reading_value, bound_value;
   logic [2:0] reading_channel, bound_channel;
   logic [1:0] bound_index;
   lrdo_limit_beeper_mode_e panel_limit_beeper_mode_mode, limit_beeper_mode;
   logic [4:0] limit_out, limit_oe, pin_level;
   int num_errors = 0;
   int samples_checked = 0;
   int vals[5] = '{-10, 10, -25, 25, 0};
   logic [4:0] masks[5] = '{5'h11, 5'h12, 5'h15, 5'h1a, 5'h00};
   // Block under test with short latency counts
   lrdo_top #(.DLY_NOCH_CYC(5), .DLY_CHAN_CYC(20)) dut_u (.clk, .rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .reading_valid,
      .reading_value, .reading_channel, .control_source_pass, .scan_active, .scan_start,
      .bound_we, .bound_channel, .bound_index, .bound_value, .advanced_scan, .panel_limit_beeper_mode_we,
      .panel_limit_beeper_mode_mode, .limit_beeper_mode, .trigger_in, .trigger_in_enable(trig_en_pin),
      .external_trigger, .limit_out, .limit_oe);
   lrdo_far_side far_u (.limit_out, .limit_oe, .hold_trig_low, .trig_en_pin, .pin_level);
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One bus transfer, held until ready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         give_verdict();
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One reading, then a fixed wait
   task automatic rd(input int v, input logic [2:0] ch, input int w);
      @(posedge clk);
      reading_value <= 33'(v);
      reading_channel <= ch;
      reading_valid <= 1'b1;
      @(posedge clk);
      reading_valid <= 1'b0;
      repeat (w) @(posedge clk);
   endtask : rd
   // One bound write from the arithmetic side
   task automatic bnd(input int c, input int i, input int v);
      @(posedge clk);
      bound_we <= 1'b1;
      bound_channel <= 3'(c);
      bound_index <= 2'(i);
      bound_value <= 33'(v);
      @(posedge clk);
      bound_we <= 1'b0;
   endtask : bnd
   // One-cycle strobe: 0 source pass, 1 scan start, 2 panel beeper
   task automatic strobe(input int s);
      @(posedge clk);
      {panel_limit_beeper_mode_we, scan_start, control_source_pass} <= 3'(1 << s);
      @(posedge clk);
      {panel_limit_beeper_mode_we, scan_start, control_source_pass} <= 3'h0;
      repeat (3) @(posedge clk);
   endtask : strobe
   // Counts and verdict
   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict
   // Main sequence
   initial begin
      {psel, penable, pwrite, reading_valid, control_source_pass, scan_active} = '0;
      {scan_start, bound_we, advanced_scan, panel_limit_beeper_mode_we, trigger_in, hold_trig_low} = '0;
      {paddr, pwdata, reading_value, bound_value, reading_channel} = '0;
      {bound_channel, bound_index} = '0;
      pstrb = 4'hf;
      panel_limit_beeper_mode_mode = lrdo_limit_beeper_mode_disabled;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      apb(0, LRDO_PULSE_OFS, 0);
      chk("pulse reset", LRDO_PULSE_MS_RST, rdat);
      apb(0, 8'h10, 0);
      chk("unmapped", 32'h1, {31'h0, err});
      // Per-channel store, so channel 1 does not land on the shared set
      advanced_scan <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < 4; i++) begin
            bnd(c, i, (i[0] ? 10 : -10) * (i[1] ? 2 : 1) * (c ? 10 : 1));
         end
      end
      advanced_scan <= 1'b0;
      rd(15, 0, 9);
      chk("off pins", 32'h1f, {27'h0, pin_level});
      for (int p = 0; p < 2; p++) begin
         apb(1, LRDO_CTRL_OFS, p ? 32'h5 : 32'h1);
         foreach (vals[k]) begin
            rd(vals[k], 0, 9);
            chk("pins", {27'h0, masks[k] ^ {5{p[0]}}}, {27'h0, pin_level});
         end
      end
      apb(1, LRDO_CTRL_OFS, 32'hd);
      for (int s = 0; s < 2; s++) begin
         scan_active <= s[0];
         rd(15, 0, 9);
         rd(0, 0, 9);
         chk("held", 32'h0f, {27'h0, pin_level});
         strobe(0);
         // Lines follow the next update once the hold is dropped
         rd(0, 0, 9);
         chk("pass", s ? 32'h0f : 32'h1f, {27'h0, pin_level});
      end
      strobe(1);
      rd(0, 0, 9);
      chk("new scan", 32'h1f, {27'h0, pin_level});
      scan_active <= 1'b0;
      apb(1, LRDO_CTRL_OFS, 32'h7);
      rd(15, 0, 9);
      chk("pulse on", 32'h0d, {27'h0, pin_level});
      rd(0, 0, 9);
      chk("pulse cut", 32'h1f, {27'h0, pin_level});
      for (int i = 0; i < 2; i++) begin
         apb(1, LRDO_PULSE_OFS, i ? 32'hffff_ffff : 32'h0);
         apb(0, LRDO_PULSE_OFS, 0);
         chk("pulse width", i ? LRDO_PULSE_MS_MAX : 32'h1, rdat);
      end
      apb(1, LRDO_CTRL_OFS, 32'h5);
      for (int t = 0; t < 2; t++) begin
         apb(1, LRDO_TRIG_OFS, t ? 32'h3 : 32'h1);
         rd(15, 0, t ? 150 : 12);
         chk("early", 32'h1f, {27'h0, pin_level});
         repeat (t ? 70 : 14) @(posedge clk);
         chk("late", 32'h0d, {27'h0, pin_level});
         rd(0, 0, t ? 230 : 30);
      end
      apb(1, LRDO_TRIG_OFS, 0);
      advanced_scan <= 1'b1;
      rd(15, 1, 9);
      chk("own set", 32'h1f, {27'h0, pin_level});
      advanced_scan <= 1'b0;
      rd(15, 1, 9);
      chk("shared set", 32'h0d, {27'h0, pin_level});
      apb(1, LRDO_CTRL_OFS, 32'h0);
      repeat (2) @(posedge clk);
      chk("disabled", 32'h1f, {27'h0, pin_level});
      apb(1, LRDO_CTRL_OFS, 32'h15);
      panel_limit_beeper_mode_mode <= lrdo_limit_beeper_mode_outside;
      strobe(2);
      apb(0, LRDO_CTRL_OFS, 0);
      chk("beeper", 32'h25, rdat);
      trigger_in <= 1'b1;
      repeat (2) @(posedge clk);
      chk("trigger", 32'h1, {31'h0, external_trigger});
      hold_trig_low <= 1'b1;
      repeat (2) @(posedge clk);
      chk("trigger off", 32'h0, {31'h0, external_trigger});
      give_verdict();
   end
endmodule : tb
